// ### rtl/spm_pkg.sv
/*
 * Shared constants and carriers for the servo pulse and monitor configuration block.
 * Assumes a single 25 MHz clock and an APB master with 32-bit data.
 */
package spm_pkg;

   // ********************************************************
   // Register byte offsets
   // ********************************************************
   localparam logic [11:0] OFS_MON_ONE = 12'h000;
   localparam logic [11:0] OFS_MON_TWO = 12'h004;
   localparam logic [11:0] OFS_PULSE_FMT = 12'h008;
   localparam logic [11:0] OFS_PULSE_NUM = 12'h00C;
   localparam logic [11:0] OFS_PULSE_DEN = 12'h010;
   localparam logic [11:0] OFS_SENSOR_DIV = 12'h014;
   localparam logic [11:0] OFS_SPEED_SCALE = 12'h018;
   localparam logic [11:0] OFS_CURRENT_SCALE = 12'h01C;
   localparam logic [11:0] OFS_INPUT_OFFSET = 12'h020;
   localparam logic [11:0] OFS_CONTROL = 12'h024;
   localparam logic [11:0] OFS_POSITION = 12'h028;

   // ********************************************************
   // Reset values
   // ********************************************************
   localparam logic [15:0] RST_MON_ONE = 16'h202A;
   localparam logic [15:0] RST_MON_TWO = 16'h2029;
   localparam logic [7:0] RST_PULSE_FMT = 8'h00;
   localparam logic [31:0] RST_PULSE_NUM = 32'h0000_0800;
   localparam logic [15:0] RST_PULSE_DEN = 16'h0001;
   localparam logic [15:0] RST_SENSOR_DIV = 16'h0000;
   localparam logic [15:0] RST_SPEED_SCALE = 16'h1770;
   localparam logic [15:0] RST_CURRENT_SCALE = 16'h0708;

   // ********************************************************
   // Field positions
   // ********************************************************
   localparam int MON_ID_MSB = 11;
   localparam int MON_GAIN_LSB = 12;
   localparam int FMT_MODE_MSB = 1;
   localparam int FMT_POLARITY_INVERT_BIT = 7;
   localparam int CTL_CMD_PULSE_BIT = 0;
   localparam int CTL_SENSOR_LSB = 4;
   localparam int CTL_OFFSET_ADJ_BIT = 8;

   // ********************************************************
   // Encodings and limits
   // ********************************************************
   localparam logic [1:0] MODE_FWD_REV = 2'h0;
   localparam logic [1:0] MODE_PULSE_DIR = 2'h1;
   localparam logic [16:0] MON_MIDSCALE = 17'h0_8000;
   localparam logic [15:0] MON_CODE_MAX = 16'hFFFF;
   localparam logic [14:0] SENSE_BASE_1X = 15'h2000;
   localparam logic [14:0] SENSE_BASE_2X = 15'h1000;
   localparam logic [14:0] SENSE_N_MAX_RESOLVER = 15'h0800;
   localparam logic [14:0] SENSE_N_MAX_ENCODER = 15'h2000;
   localparam int ANALOG_FULL_SCALE_SHIFT = 15;
   localparam logic [15:0] OFFSET_MAX = 16'h7FFF;

   typedef enum logic [1:0] {
      SENSOR_RESOLVER_1X,
      SENSOR_RESOLVER_2X,
      SENSOR_INC_REDUCED,
      SENSOR_ENC_17BIT
   } spm_sensor_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } spm_apb_req_type;

endpackage

// ### rtl/spm_top.sv
/*
 * Servo pulse and monitor configuration block: APB register file, two analog monitor
 * channels, command pulse decoder with n/m scaling, sensor output divider and analog
 * command scaling.
 * Assumes all pin inputs are synchronous to clk and the monitored values are supplied
 * by the drive core for the identifier this block presents.
 */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// ********************************************************
// Monitor channel
// ********************************************************
module spm_monitor_ch (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Setting and value
   input wire logic [15:0] select,
   input wire logic [31:0] value,
   // Results
   output logic [11:0] param_id,
   output logic [15:0] code
);
   logic signed [15:0] low_value;
   logic [3:0] gain;
   logic signed [47:0] scaled;
   logic signed [47:0] summed;
   logic [15:0] next_code;

   assign gain = select[15:spm_pkg::MON_GAIN_LSB];
   assign low_value = $signed(value[15:0]);
   assign scaled = 48'(signed'(low_value)) <<< gain;
   // Full scale of the converter is 5 V over 65536 codes, so 2.5 V per 32768 counts.
   assign summed = scaled + 48'(signed'({1'b0, spm_pkg::MON_MIDSCALE}));
   // Saturation keeps a large gain from folding a peak onto the opposite rail.
   assign next_code = (summed < 48'sh0) ? 16'h0000 :
                      (summed > 48'(spm_pkg::MON_CODE_MAX)) ? spm_pkg::MON_CODE_MAX :
                      summed[15:0];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         param_id <= 12'h000;
         code <= spm_pkg::MON_MIDSCALE[15:0];
      end else begin
         param_id <= select[spm_pkg::MON_ID_MSB:0];
         code <= next_code;
      end
   end
endmodule

// Functional notes
// - A monitor selection word carries the parameter identifier in its low 12 bits and the gain exponent in its high 4 bits.
// - Each monitor output sits at 2.5 V midscale plus the value times two to the gain, at 2.5 V per 32768 counts.
// - The monitored value is 16 bits and only the low half of a 32-bit parameter is shown.
// - Pulse mode 00 decodes separate forward and reverse lines and mode 01 decodes pulse plus direction.
// - When the polarity invert bit is set the command pulse inputs are inverted before decoding.
// - Command pulses are scaled to position by numerator over denominator, the denominator being 1 to 255.
// - The pulse scaling acts only while the command source selects pulse input.
// - With a one-marker resolver the sensor output is the input divided by N/8192, N from 1 to 2048.
// - With a two-marker resolver the sensor output is the input divided by N/4096, N from 1 to 2048.
// - With a reduced-wiring encoder the sensor output is divided by N/8192, N from 1 to 8192, default 8192.
// - With a 17-bit encoder the sensor output is synthesised at 1 to 8192 counts per turn.
// - A full-scale 10 V speed command equals the speed scale in rpm, 0 to 10000.
// - A full-scale 10 V current command equals the current scale in 0.01 Arms, 0 to 2400.
// - The analog offset, 0 to 32767, is set by the device during offset adjustment and is read-only.
module spm_top (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire spm_pkg::spm_apb_req_type apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Monitor value lookup
   input wire logic [31:0] mon_one_value,
   input wire logic [31:0] mon_two_value,
   output logic [11:0] mon_one_id,
   output logic [11:0] mon_two_id,
   // Monitor converter codes
   output logic [15:0] mon_one_code,
   output logic [15:0] mon_two_code,
   // Command pulse inputs
   input wire logic cmd_pulse_a,
   input wire logic cmd_pulse_b,
   // Scaled command position
   output logic [31:0] cmd_position,
   // Sensor quadrature in and divided out
   input wire logic sensor_a,
   input wire logic sensor_b,
   input wire logic sensor_z,
   output logic sense_out_a,
   output logic sense_out_b,
   output logic sense_out_z,
   // Analog commands
   input wire logic signed [15:0] analog_in,
   output logic signed [15:0] speed_cmd_rpm,
   output logic signed [15:0] current_cmd
);
   // ********************************************************
   // Register file
   // ********************************************************
   logic [15:0] monitor_one_select;
   logic [15:0] monitor_two_select;
   logic [7:0] pulse_input_format;
   logic [31:0] pulse_scale_numerator;
   logic [15:0] pulse_scale_denominator;
   logic [15:0] sensor_output_divider;
   logic [15:0] analog_speed_scale;
   logic [15:0] analog_current_scale;
   logic [15:0] analog_input_offset;
   logic cmd_source_pulse;
   spm_pkg::spm_sensor_type sensor_kind;
   logic offset_adjust;

   wire setup = apb_req.psel && !apb_req.penable;
   wire wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   wire [11:0] addr = apb_req.paddr;
   wire [31:0] wd = apb_req.pwdata;
   wire hit_mon_one = addr == spm_pkg::OFS_MON_ONE;
   wire hit_mon_two = addr == spm_pkg::OFS_MON_TWO;
   wire hit_fmt = addr == spm_pkg::OFS_PULSE_FMT;
   wire hit_num = addr == spm_pkg::OFS_PULSE_NUM;
   wire hit_den = addr == spm_pkg::OFS_PULSE_DEN;
   wire hit_div = addr == spm_pkg::OFS_SENSOR_DIV;
   wire hit_speed = addr == spm_pkg::OFS_SPEED_SCALE;
   wire hit_current = addr == spm_pkg::OFS_CURRENT_SCALE;
   wire hit_offset = addr == spm_pkg::OFS_INPUT_OFFSET;
   wire hit_ctl = addr == spm_pkg::OFS_CONTROL;
   wire hit_pos = addr == spm_pkg::OFS_POSITION;
   wire hit_any = hit_mon_one | hit_mon_two | hit_fmt | hit_num | hit_den | hit_div |
                  hit_speed | hit_current | hit_offset | hit_ctl | hit_pos;
   wire [31:0] ctl_word = {23'h0, offset_adjust, 2'h0, sensor_kind, 3'h0, cmd_source_pulse};
   wire [31:0] next_prdata =
      hit_mon_one ? {16'h0, monitor_one_select} :
      hit_mon_two ? {16'h0, monitor_two_select} :
      hit_fmt ? {24'h0, pulse_input_format} :
      hit_num ? pulse_scale_numerator :
      hit_den ? {16'h0, pulse_scale_denominator} :
      hit_div ? {16'h0, sensor_output_divider} :
      hit_speed ? {16'h0, analog_speed_scale} :
      hit_current ? {16'h0, analog_current_scale} :
      hit_offset ? {16'h0, analog_input_offset} :
      hit_ctl ? ctl_word :
      hit_pos ? cmd_position : 32'h0000_0000;

   // Every access completes in its first access cycle; read data is staged at setup.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit_any;
         if (setup) begin
            prdata <= apb_req.pwrite ? 32'h0000_0000 : next_prdata;
         end
      end
   end

   wire wr_take = wr_en && pready;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         monitor_one_select <= spm_pkg::RST_MON_ONE;
         monitor_two_select <= spm_pkg::RST_MON_TWO;
         pulse_input_format <= spm_pkg::RST_PULSE_FMT;
         pulse_scale_numerator <= spm_pkg::RST_PULSE_NUM;
         pulse_scale_denominator <= spm_pkg::RST_PULSE_DEN;
         sensor_output_divider <= spm_pkg::RST_SENSOR_DIV;
         analog_speed_scale <= spm_pkg::RST_SPEED_SCALE;
         analog_current_scale <= spm_pkg::RST_CURRENT_SCALE;
         cmd_source_pulse <= 1'b0;
         sensor_kind <= spm_pkg::SENSOR_RESOLVER_1X;
      end else if (wr_take) begin
         if (hit_mon_one) monitor_one_select <= wd[15:0];
         if (hit_mon_two) monitor_two_select <= wd[15:0];
         if (hit_fmt) pulse_input_format <= wd[7:0];
         if (hit_num) pulse_scale_numerator <= wd;
         if (hit_den) pulse_scale_denominator <= wd[15:0];
         if (hit_div) sensor_output_divider <= wd[15:0];
         if (hit_speed) analog_speed_scale <= wd[15:0];
         if (hit_current) analog_current_scale <= wd[15:0];
         if (hit_ctl) begin
            cmd_source_pulse <= wd[spm_pkg::CTL_CMD_PULSE_BIT];
            sensor_kind <= spm_pkg::spm_sensor_type'(wd[spm_pkg::CTL_SENSOR_LSB +: 2]);
         end
      end
   end

   // ********************************************************
   // Analog monitors
   // ********************************************************
   spm_monitor_ch u_mon_one (
      .clk(clk),
      .nrst(nrst),
      .select(monitor_one_select),
      .value(mon_one_value),
      .param_id(mon_one_id),
      .code(mon_one_code)
   );

   spm_monitor_ch u_mon_two (
      .clk(clk),
      .nrst(nrst),
      .select(monitor_two_select),
      .value(mon_two_value),
      .param_id(mon_two_id),
      .code(mon_two_code)
   );

   // ********************************************************
   // Command pulse decoder and n/m scaling
   // ********************************************************
   logic pa_prev;
   logic pb_prev;
   logic signed [47:0] residue;
   wire invert = pulse_input_format[spm_pkg::FMT_POLARITY_INVERT_BIT];
   wire [1:0] pmode = pulse_input_format[spm_pkg::FMT_MODE_MSB:0];
   wire pa = cmd_pulse_a ^ invert;
   wire pb = cmd_pulse_b ^ invert;
   wire pa_rise = pa && !pa_prev;
   wire pb_rise = pb && !pb_prev;
   wire step_fwd = (pmode == spm_pkg::MODE_FWD_REV) ? (pa_rise && !pb_rise) :
                   (pmode == spm_pkg::MODE_PULSE_DIR) ? (pa_rise && pb) : 1'b0;
   wire step_rev = (pmode == spm_pkg::MODE_FWD_REV) ? (pb_rise && !pa_rise) :
                   (pmode == spm_pkg::MODE_PULSE_DIR) ? (pa_rise && !pb) : 1'b0;
   // A zero denominator would stall the stepper, so it acts as one.
   wire [7:0] den8 = (pulse_scale_denominator[7:0] == 8'h00) ? 8'h01 : pulse_scale_denominator[7:0];
   wire signed [47:0] den = 48'(den8);
   wire signed [47:0] den_hi = den <<< 16;
   wire signed [47:0] den_mid = den <<< 8;
   wire signed [47:0] num = 48'(pulse_scale_numerator);
   wire signed [47:0] add_in = !cmd_source_pulse ? 48'sh0 :
                                step_fwd ? num : step_rev ? -num : 48'sh0;
   // Each cycle drains the largest of three chunks that the residue covers, so high ratios
   // still track fast pulse trains without a divider.
   wire signed [47:0] take = (residue >= den_hi) ? den_hi : (residue <= -den_hi) ? -den_hi :
                             (residue >= den_mid) ? den_mid : (residue <= -den_mid) ? -den_mid :
                             (residue >= den) ? den : (residue <= -den) ? -den : 48'sh0;
   wire signed [31:0] pos_step = (take == den_hi) ? 32'sh0001_0000 : (take == -den_hi) ? -32'sh0001_0000 :
                                 (take == den_mid) ? 32'sh0000_0100 : (take == -den_mid) ? -32'sh0000_0100 :
                                 (take == den) ? 32'sh0000_0001 : (take == -den) ? -32'sh0000_0001 : 32'sh0;
   wire signed [47:0] next_residue = residue - take + add_in;
   wire [31:0] next_position = cmd_position + 32'(pos_step);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pa_prev <= 1'b0;
         pb_prev <= 1'b0;
         residue <= 48'sh0;
         cmd_position <= 32'h0000_0000;
      end else begin
         pa_prev <= pa;
         pb_prev <= pb;
         residue <= next_residue;
         cmd_position <= next_position;
      end
   end

   // ********************************************************
   // Sensor output frequency division
   // ********************************************************
   logic sa_prev;
   logic sb_prev;
   logic signed [15:0] sense_acc;
   logic [1:0] out_phase;
   wire [1:0] in_prev = {sa_prev, sa_prev ^ sb_prev};
   wire [1:0] in_now = {sensor_a, sensor_a ^ sensor_b};
   wire cnt_up = in_now == in_prev + 2'h1;
   wire cnt_dn = in_now == in_prev - 2'h1;
   wire is_resolver = (sensor_kind == spm_pkg::SENSOR_RESOLVER_1X) ||
                      (sensor_kind == spm_pkg::SENSOR_RESOLVER_2X);
   wire [14:0] n_max = is_resolver ? spm_pkg::SENSE_N_MAX_RESOLVER : spm_pkg::SENSE_N_MAX_ENCODER;
   wire [14:0] base = (sensor_kind == spm_pkg::SENSOR_RESOLVER_2X) ? spm_pkg::SENSE_BASE_2X :
                      spm_pkg::SENSE_BASE_1X;
   // A zero setting selects the type's own default, which is its maximum N.
   wire [14:0] n_raw = sensor_output_divider[14:0];
   wire [14:0] n_eff = (n_raw == 15'h0 || sensor_output_divider[15] || n_raw > n_max) ? n_max : n_raw;
   wire signed [15:0] acc_add = sense_acc + (cnt_up ? 16'(n_eff) : cnt_dn ? -16'(n_eff) : 16'sh0);
   // The base is compared as a signed quantity, otherwise a negative sum would read as a huge count.
   wire signed [15:0] base_s = 16'(base);
   wire out_up = acc_add >= base_s;
   wire out_dn = acc_add <= -base_s;
   wire signed [15:0] next_acc = out_up ? acc_add - 16'(base) : out_dn ? acc_add + 16'(base) : acc_add;
   wire [1:0] next_phase = out_up ? out_phase + 2'h1 : out_dn ? out_phase - 2'h1 : out_phase;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sa_prev <= 1'b0;
         sb_prev <= 1'b0;
         sense_acc <= 16'sh0;
         out_phase <= 2'h0;
         sense_out_a <= 1'b0;
         sense_out_b <= 1'b0;
         sense_out_z <= 1'b0;
      end else begin
         sa_prev <= sensor_a;
         sb_prev <= sensor_b;
         sense_acc <= next_acc;
         out_phase <= next_phase;
         sense_out_a <= next_phase[1];
         sense_out_b <= next_phase[1] ^ next_phase[0];
         sense_out_z <= sensor_z;
      end
   end

   // ********************************************************
   // Analog command scaling and offset adjustment
   // ********************************************************
   wire signed [16:0] corrected = 17'(analog_in) - 17'(signed'({1'b0, analog_input_offset}));
   wire signed [15:0] sat_in = (corrected > 17'sh07FFF) ? 16'sh7FFF :
                               (corrected < -17'sh08000) ? -16'sh8000 : corrected[15:0];
   wire signed [32:0] speed_prod = 33'(sat_in) * 33'(signed'({1'b0, analog_speed_scale}));
   wire signed [32:0] current_prod = 33'(sat_in) * 33'(signed'({1'b0, analog_current_scale}));
   wire signed [32:0] speed_q = speed_prod >>> spm_pkg::ANALOG_FULL_SCALE_SHIFT;
   wire signed [32:0] current_q = current_prod >>> spm_pkg::ANALOG_FULL_SCALE_SHIFT;
   wire adj_req = wr_take && hit_ctl && wd[spm_pkg::CTL_OFFSET_ADJ_BIT];
   wire [15:0] offset_cap = analog_in[15] ? 16'h0000 : (16'(analog_in) & spm_pkg::OFFSET_MAX);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         offset_adjust <= 1'b0;
         analog_input_offset <= 16'h0000;
         speed_cmd_rpm <= 16'sh0;
         current_cmd <= 16'sh0;
      end else begin
         offset_adjust <= adj_req;
         // The capture happens one cycle after the request, with the input at rest.
         if (offset_adjust) analog_input_offset <= offset_cap;
         speed_cmd_rpm <= speed_q[15:0];
         current_cmd <= current_q[15:0];
      end
   end
endmodule

// ### tb/spm_props.sv
/*
 * Port checker for spm_top: bus timing, monitor codes and sensor outputs.
 * Assumes one clock and the synchronous active-low reset of the block.
 */
`timescale 1ns/1ps

// ********************************************************
// Checker
// ********************************************************
module spm_props (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bus
   input wire spm_pkg::spm_apb_req_type apb_req,
   input wire logic pready,
   input wire logic pslverr,
   // Monitor channel one
   input wire logic [31:0] mon_one_value,
   input wire logic [11:0] mon_one_id,
   input wire logic [15:0] mon_one_code,
   // Sensor
   input wire logic sensor_z,
   input wire logic sense_out_a,
   input wire logic sense_out_b,
   input wire logic sense_out_z
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_wr_mon;
      apb_req.psel && apb_req.penable && pready && apb_req.pwrite && apb_req.paddr == spm_pkg::OFS_MON_ONE;
   endsequence
   property p_ready_next;
      s_setup |=> pready;
   endproperty
   property p_ready_once;
      pready |=> !pready;
   endproperty
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   property p_id;
      s_wr_mon |=> ##1 mon_one_id == $past(apb_req.pwdata[11:0], 2);
   endproperty
   property p_mid;
      mon_one_value[15:0] == 16'h0000 |=> mon_one_code == 16'h8000;
   endproperty
   property p_sign;
      mon_one_value[15:0] != 16'h0000 |=> mon_one_code[15] == !$past(mon_one_value[15]);
   endproperty
   property p_z;
      $past(nrst) |-> sense_out_z == $past(sensor_z);
   endproperty
   property p_gray;
      $past(nrst) |-> !($changed(sense_out_a) && $changed(sense_out_b));
   endproperty
   a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
   a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   a_id: assert property (p_id) else $error("monitor id not taken from select");
   a_mid: assert property (p_mid) else $error("zero value not at midscale");
   a_sign: assert property (p_sign) else $error("monitor code wrapped");
   a_z: assert property (p_z) else $error("marker output not one cycle late");
   a_gray: assert property (p_gray) else $error("sensor output not gray");
endmodule

bind spm_top spm_props i_props (.clk(clk), .nrst(nrst), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
   .mon_one_value(mon_one_value), .mon_one_id(mon_one_id), .mon_one_code(mon_one_code), .sensor_z(sensor_z),
   .sense_out_a(sense_out_a), .sense_out_b(sense_out_b), .sense_out_z(sense_out_z));

// ### tb/spm_pulse_src.sv
/*
 * Model of the external motion controller issuing command pulses.
 * Assumes the bench starts a burst only while the model is idle.
 */
`timescale 1ns/1ps

// ********************************************************
// Pulse source
// ********************************************************
module spm_pulse_src (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Request from the bench
   input wire logic start,
   input wire logic [7:0] num_pulses,
   input wire logic reverse,
   input wire logic pulse_dir,
   input wire logic invert,
   // Pins towards the drive, busy flag back to the bench
   output logic pin_a,
   output logic pin_b,
   output logic busy
);
   logic [8:0] left = 9'h000;
   always @(posedge clk) begin
      if (!nrst) begin
         left <= 9'h000;
      end else if (start && left == 9'h000) begin
         left <= {num_pulses, 1'b0};
      end else if (left != 9'h000) begin
         left <= left - 9'h001;
      end
   end
   // A low cycle leads each burst, so the direction line settles before the first pulse.
   assign busy = left != 9'h000;
   assign pin_a = (left[0] & (pulse_dir | ~reverse)) ^ invert;
   assign pin_b = (pulse_dir ? ~reverse : left[0] & reverse) ^ invert;
endmodule

// ### tb/tb_spm_top.sv
/*
 * Self-checking bench for spm_top.
 * Assumes spm_props is bound and spm_pulse_src stands in for the motion controller.
 */
`timescale 1ns/1ps

// ********************************************************
// Bench
// ********************************************************
module tb_spm_top;
   logic clk = 0;
   logic nrst = 0;
   spm_pkg::spm_apb_req_type req = '0;
   logic [31:0] prdata, pos, q, mv1 = 0, mv2 = 0;
   logic pready, pslverr, e, oa, ob, oz, pa, pb, busy, poa = 0, pob = 0;
   logic sa = 0, sb = 0, sz = 0, go = 0, rev = 0, pdir = 0, inv = 0;
   logic [7:0] npul = 0;
   logic [11:0] id1, id2;
   logic [15:0] c1, c2;
   logic signed [15:0] ain = 0, spd, cur;
   int num_errors = 0, num_checks = 0, edges = 0, gi = 0;
   always #20 clk = ~clk;
   always @(posedge clk) begin
      poa <= oa;
      pob <= ob;
      if (nrst && (oa !== poa || ob !== pob)) edges <= edges + 1;
   end
   spm_top i_dut (.clk(clk), .nrst(nrst), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mon_one_value(mv1), .mon_two_value(mv2), .mon_one_id(id1), .mon_two_id(id2), .mon_one_code(c1),
      .mon_two_code(c2), .cmd_pulse_a(pa), .cmd_pulse_b(pb), .cmd_position(pos), .sensor_a(sa), .sensor_b(sb),
      .sensor_z(sz), .sense_out_a(oa), .sense_out_b(ob), .sense_out_z(oz), .analog_in(ain),
      .speed_cmd_rpm(spd), .current_cmd(cur));
   spm_pulse_src i_src (.clk(clk), .nrst(nrst), .start(go), .num_pulses(npul), .reverse(rev), .pulse_dir(pdir),
      .invert(inv), .pin_a(pa), .pin_b(pb), .busy(busy));
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 20) chk("pready", 1, 0);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, x, q);
   endtask
   task t_regs;
      chk("id1", 32'h02A, id1);
      chk("id2", 32'h029, id2);
      rd(spm_pkg::OFS_MON_ONE, 32'h202A, "mon1");
      rd(spm_pkg::OFS_MON_TWO, 32'h2029, "mon2");
      rd(spm_pkg::OFS_PULSE_FMT, 32'h00, "fmt");
      rd(spm_pkg::OFS_PULSE_NUM, 32'h800, "num");
      rd(spm_pkg::OFS_PULSE_DEN, 32'h1, "den");
      rd(spm_pkg::OFS_SPEED_SCALE, 32'h1770, "spd scale");
      rd(spm_pkg::OFS_CURRENT_SCALE, 32'h708, "cur scale");
      rd(12'h030, 32'h0, "unmapped");
      chk("slverr", 1, e);
   endtask
   task t_monitor;
      wr(spm_pkg::OFS_MON_ONE, 32'h3029);
      mv1 <= 32'h0000_07D0;
      mv2 <= 32'h0000_0064;
      cyc(3);
      chk("id1 set", 32'h029, id1);
      chk("code +", 32'hBE80, c1);
      chk("code two", 32'h8190, c2);
      mv1 <= 32'hFFFF_F448;
      cyc(3);
      chk("code -", 32'h2240, c1);
      mv1 <= 32'h1234_07D0;
      cyc(3);
      chk("code low half", 32'hBE80, c1);
      wr(spm_pkg::OFS_MON_ONE, 32'hE029);
      cyc(3);
      chk("clamp hi", 32'hFFFF, c1);
      mv1 <= 32'h0000_8000;
      cyc(3);
      chk("clamp lo", 32'h0, c1);
   endtask
   task send(input logic [7:0] k, input logic r);
      int n;
      n = 0;
      rev <= r;
      npul <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b0 && n < 600);
      cyc(20);
   endtask
   task t_pulse;
      logic [31:0] b;
      wr(spm_pkg::OFS_PULSE_NUM, 32'h3);
      wr(spm_pkg::OFS_PULSE_DEN, 32'h2);
      for (int m = 0; m < 4; m++) begin
         // Format and pins change only while counting is off, so the switch adds no edge.
         wr(spm_pkg::OFS_CONTROL, 32'h0);
         wr(spm_pkg::OFS_PULSE_FMT, {24'h0, m[1], 6'h0, m[0]});
         pdir <= m[0];
         inv <= m[1];
         cyc(4);
         wr(spm_pkg::OFS_CONTROL, 32'h1);
         b = pos;
         send(8'd4, 1'b0);
         chk("pos fwd", b + 32'd6, pos);
         send(8'd2, 1'b1);
         chk("pos rev", b + 32'd3, pos);
      end
      rd(spm_pkg::OFS_POSITION, 32'd12, "pos reg");
      wr(spm_pkg::OFS_CONTROL, 32'h0);
      b = pos;
      send(8'd3, 1'b0);
      chk("pos off", b, pos);
   endtask
   task t_sensor;
      logic [15:0] nv[4] = '{16'd2048, 16'd2048, 16'd8192, 16'd1024};
      int xs[4] = '{4, 8, 16, 2};
      for (int t = 0; t < 4; t++) begin
         wr(spm_pkg::OFS_CONTROL, t << 4);
         wr(spm_pkg::OFS_SENSOR_DIV, {16'h0, nv[t]});
         edges = 0;
         for (int i = 0; i < 16; i++) begin
            gi = (t == 3) ? (gi + 3) % 4 : (gi + 1) % 4;
            sa <= gi[1];
            sb <= gi[1] ^ gi[0];
            sz <= i[2];
            cyc(2);
         end
         cyc(4);
         chk("out steps", xs[t], edges);
      end
   endtask
   task t_analog;
      ain <= 16'sh0000;
      wr(spm_pkg::OFS_CONTROL, 32'h100);
      cyc(4);
      rd(spm_pkg::OFS_INPUT_OFFSET, 32'h0, "offset zero");
      wr(spm_pkg::OFS_SPEED_SCALE, 32'h2710);
      wr(spm_pkg::OFS_CURRENT_SCALE, 32'h960);
      ain <= 16'sh7FFF;
      cyc(3);
      chk("speed", 32'h270F, spd);
      chk("current", 32'h95F, cur);
      ain <= 16'sh1234;
      wr(spm_pkg::OFS_CONTROL, 32'h100);
      cyc(4);
      wr(spm_pkg::OFS_INPUT_OFFSET, 32'h55);
      rd(spm_pkg::OFS_INPUT_OFFSET, 32'h1234, "offset ro");
      chk("speed offset", 32'h0, spd);
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      cyc(2);
      nrst <= 1'b1;
      cyc(2);
      t_regs;
      t_monitor;
      t_pulse;
      t_sensor;
      t_analog;
      tally_and_finish;
   end
   initial begin
      #2000000;
      num_errors++;
      tally_and_finish;
   end
endmodule
